// [hdl/sarc_pkg.sv]
package sarc_pkg;
  // Bus width of the result
  localparam int RES_W = 16;
  // Conversion timing
  localparam int CLK_MHZ = 50;
  localparam int CONV_MAX_NS = 2500;
  localparam int CONV_CYC = (CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int NAP_HIGH_NS = 250;
  localparam int NAP_HIGH_CYC = (NAP_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // Host-side control pins, grouped
  typedef struct packed {
    logic power_down;
    logic reset;
    logic interface_kind_select;
    logic byte_order_select;
    logic code_format_select;
    logic cs_n;
    logic rd_n;
  } sarc_ctrl_t;
endpackage : sarc_pkg

// [hdl/sarc_top.sv]
// Overview of operation
// [RULE1] First conversion after power-up gives a valid result; no dummy conversion.
// [RULE2] Nap: strobe low between conversions; high 250ns then low starts the next.
// [RULE3] While power-down is high, conversion requests are ignored.
// [RULE4] Power-down during conversion lets it finish; result stays readable.
// [RULE5] Host reads pending result before asserting power-down, unless converting.
// [RULE6] Host waits about 5ms after power-down release with external reference.
// [RULE7] Falling strobe starts a conversion; no restart until it completes.
// [RULE8] Busy is high for the whole conversion and low otherwise.
// [RULE9] Host raises strobe within 40ns of start or after conversion ends.
// [RULE10] Conversion lasts at most 2500ns; with 1485ns acquisition gives 250ksps.
// [RULE11] Chip select or read strobe high puts all data outputs in high impedance.
// [RULE12] Parallel kind with select and read low drives the 16-bit result.
// [RULE13] Byte order low: high byte on top lanes; high: halves exchanged.
// [RULE14] Serial kind with select and read low shifts result out; bus stays off.
// [RULE15] Serial data changes on rising shift clock; host samples on falling.
// [RULE16] Top bit first, valid until rising edge after first falling edge.
// [RULE17] Host runs shift clock at 15MHz or faster for full throughput.
// [RULE18] Host shifts the full result before raising select and read strobe.
// [RULE19] Chain input captured on falling edges, passed behind local result.
// [RULE20] Format high gives offset binary; low inverts the top bit, both modes.
// [RULE21] Reset high aborts conversion, floats the bus, ignores requests.
// [RULE22] Host waits acquisition time plus 2us after reset before converting.
// [RULE23] After 16 own bits, chain bits follow in order, one shift clock late; the code sends them with no gap, 16 rising edges after capture.
`timescale 1ns/1ns
`default_nettype none
module sarc_top
  import sarc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  // System clock and control
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Conversion strobe and control pins (asynchronous)
  input  wire logic              conversion_start_n,
  input  wire sarc_ctrl_t        ctrl,
  // Converter core sample
  input  wire logic [RES_W-1:0]  sample_code,
  // Parallel bus
  output logic [RES_W-1:0]       data_out,
  output logic [RES_W-1:0]       data_oe,
  output logic                   busy,
  // Serial link
  input  wire logic              shift_clk,
  input  wire logic              chain_input,
  output logic                   serial_result_out,
  output logic                   serial_oe
);
  initial begin
    if (CONV_CYCLES < 2 || CONV_CYCLES > CONV_CYC) $error("CONV_CYCLES out of range");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DOWN} sarc_state_t;

  typedef struct packed {
    logic [1:0]       strb_sync;
    logic             strb_prev;
    sarc_ctrl_t       c_meta;
    sarc_ctrl_t       c_sync;
    sarc_state_t      st;
    logic [7:0]       cnt;
    logic [RES_W-1:0] result;
    logic             res_tgl;
    logic             ack_meta;
    logic             ack_sync;
    logic [RES_W-1:0] dout;
    logic [RES_W-1:0] doe;
    logic             busy;
  } sarc_core_t;

  sarc_core_t s_q, s_d;
  logic       strobe_fall;
  logic       bus_on;
  logic [RES_W-1:0] fmt;

  // Apply code format and byte order to the stored result
  function automatic logic [RES_W-1:0] sarc_format(input logic [RES_W-1:0] r, input logic ob,
                                                   input logic swap);
    logic [RES_W-1:0] v;
    v = {r[RES_W-1] ^ ~ob, r[RES_W-2:0]}; // [RULE20]
    return swap ? {v[7:0], v[15:8]} : v; // [RULE13]
  endfunction : sarc_format

  assign strobe_fall = s_q.strb_prev & ~s_q.strb_sync[1];
  assign bus_on = ~s_q.c_sync.cs_n & ~s_q.c_sync.rd_n & ~s_q.c_sync.reset;
  assign fmt = sarc_format(s_q.result, s_q.c_sync.code_format_select,
                           s_q.c_sync.byte_order_select);

  // Control path: sync, conversion timing, output bus
  always_comb begin
    s_d = s_q;
    s_d.strb_sync = {s_q.strb_sync[0], conversion_start_n};
    s_d.strb_prev = s_q.strb_sync[1];
    s_d.c_meta = ctrl;
    s_d.c_sync = s_q.c_meta;
    // Acknowledge toggle from the link domain, two stages as the clk side runs freely
    s_d.ack_meta = l_q.taken;
    s_d.ack_sync = s_q.ack_meta;
    case (s_q.st)
      ST_IDLE: begin
        // Nap needs no timer here: any high then falling strobe starts
        if (strobe_fall && !s_q.c_sync.power_down && !s_q.c_sync.reset) begin // [RULE7] [RULE3] [RULE2]
          s_d.st = ST_CONV;
          s_d.cnt = 8'h00;
        end else if (s_q.c_sync.power_down) begin
          s_d.st = ST_DOWN;
        end
      end
      ST_CONV: begin
        // Strobe edges are ignored while converting; power-down waits
        if (s_q.cnt == 8'(CONV_CYCLES - 1)) begin // [RULE10] [RULE4]
          s_d.result = sample_code;
          // Raise a new request only once the previous one was taken, so that
          // several results with no frame between them cannot alias the toggle
          if (s_q.res_tgl == s_q.ack_sync) begin
            s_d.res_tgl = ~s_q.res_tgl;
          end
          s_d.st = s_q.c_sync.power_down ? ST_DOWN : ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      ST_DOWN: begin
        if (!s_q.c_sync.power_down) begin
          s_d.st = ST_IDLE; // Result kept across shutdown [RULE4]
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (s_q.c_sync.reset) begin // [RULE21]
      s_d.st = ST_IDLE;
      s_d.cnt = 8'h00;
    end
    s_d.busy = (s_d.st == ST_CONV); // [RULE8]
    s_d.dout = fmt;
    s_d.doe = (bus_on && !s_q.c_sync.interface_kind_select) ? '1 : '0; // [RULE11] [RULE12] [RULE14]
  end

  // Power-on state: first conversion already valid, no warm-up [RULE1]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.strb_sync <= 2'h3;
      s_q.strb_prev <= 1'b1;
      s_q.c_meta.cs_n <= 1'b1;
      s_q.c_meta.rd_n <= 1'b1;
      s_q.c_sync.cs_n <= 1'b1;
      s_q.c_sync.rd_n <= 1'b1;
      s_q.result <= RESULT_RST;
      s_q.st <= ST_IDLE;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign data_out = s_q.dout;
  assign data_oe = s_q.doe;
  assign busy = s_q.busy;

  // Link domain. The shift clock belongs to the host and stands still between
  // frames, so no synchroniser in this domain could settle before the first
  // edge of a frame. The result is handed over by a request and acknowledge
  // toggle pair instead; the request is settled a conversion time before any
  // legal read, which is what lets the first edge of a frame act on it.
  // Limitation: a frame that starts just as a conversion ends may see either word.
  typedef struct packed {
    logic             taken;
    logic [RES_W-1:0] shreg;
    logic             sout;
  } sarc_link_t;

  sarc_link_t       l_q, l_d;
  logic             link_en;
  logic             word_new;
  logic [RES_W-1:0] word_ser;
  logic             chain_q;

  // Gate pins stand still for a whole frame by the host's side of the contract
  assign link_en = ~ctrl.cs_n & ~ctrl.rd_n & ctrl.interface_kind_select & ~ctrl.reset;

  // A request is pending that this domain has not yet taken
  assign word_new = s_q.res_tgl != l_q.taken;

  // Serial words are never byte swapped; only the format bit applies
  assign word_ser = sarc_format(s_q.result, ctrl.code_format_select, 1'b0); // [RULE20]

  // Rising edge: load a new or gated-off word, else shift one place
  always_comb begin
    l_d = l_q;
    if (!link_en || word_new) begin
      l_d.shreg = word_ser; // Top bit out at first rise, held to the next [RULE16]
      l_d.taken = s_q.res_tgl;
    end else begin
      l_d.shreg = {l_q.shreg[RES_W-2:0], chain_q}; // [RULE23] [RULE15]
    end
    l_d.sout = l_d.shreg[RES_W-1];
  end

  always_ff @(posedge shift_clk) begin
    if (!rst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Chain input captured on the falling shift clock edge, used at the next rise
  always_ff @(negedge shift_clk) begin
    if (!rst_n) begin
      chain_q <= 1'b0;
    end else begin
      chain_q <= chain_input; // [RULE19]
    end
  end

  assign serial_result_out = l_q.sout;

  // Output enable follows the gate pins in the system domain
  logic soe_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soe_q <= 1'b0;
    end else if (clk_en) begin
      soe_q <= bus_on & s_q.c_sync.interface_kind_select; // [RULE14] [RULE11]
    end
  end
  assign serial_oe = soe_q;

  // Checks in the system domain
  // Busy may end early only when the reset pin is on its way in
  a_busy_len: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE8]
    (busy && s_q.cnt != 8'(CONV_CYCLES - 1) && !s_q.c_meta.reset && !s_q.c_sync.reset)
    |=> busy) else $error("busy too short");

  a_no_start_pd: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE3]
    (s_q.st == ST_IDLE && s_q.c_sync.power_down) |=> !busy)
    else $error("start in shutdown");

  a_reset_abort: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE21]
    s_q.c_sync.reset |=> !busy)
    else $error("busy in reset");

  a_bus_float: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE11]
    !bus_on |=> data_oe == '0)
    else $error("bus driven when off");

  a_bus_drive: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE12]
    (bus_on && !s_q.c_sync.interface_kind_select) |=> data_oe == '1)
    else $error("bus off");

  a_busy_max: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE10]
    (s_q.st == ST_CONV && s_q.cnt == 8'(CONV_CYCLES - 1)) |=> !busy)
    else $error("too long");

  // Power-down during a conversion lets it run on, then shuts down
  a_pd_finish: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE4]
    (s_q.st == ST_CONV && s_q.c_sync.power_down && !s_q.c_meta.reset && !s_q.c_sync.reset)
    |=> (busy || s_q.st == ST_DOWN))
    else $error("conversion cut");

  // The stored result only moves at the end of a conversion
  a_result_hold: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE4]
    (s_q.st != ST_CONV) |=> $stable(s_q.result))
    else $error("result moved");

  a_format_msb: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE20]
    !s_q.c_sync.byte_order_select
    |-> fmt == {s_q.result[RES_W-1] ^ !s_q.c_sync.code_format_select, s_q.result[RES_W-2:0]})
    else $error("format wrong");

  a_swap_bytes: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE13]
    s_q.c_sync.byte_order_select
    |-> (fmt[RES_W-1:8] == s_q.result[7:0] && fmt[6:0] == s_q.result[RES_W-2:8]))
    else $error("bytes not swapped");

  // Parallel and serial drivers are never on together
  a_oe_split: assert property (@(posedge clk) disable iff (!rst_n || !clk_en) // [RULE14]
    !(data_oe != '0 && serial_oe))
    else $error("both outputs on");

  // Checks in the link domain
  a_link_load: assert property (@(posedge shift_clk) disable iff (!rst_n) // [RULE16]
    (!link_en || word_new) |=> serial_result_out == $past(word_ser[RES_W-1]))
    else $error("top bit not loaded");

  a_chain_shift: assert property (@(posedge shift_clk) disable iff (!rst_n) // [RULE19]
    (link_en && !word_new) |=> l_q.shreg[0] == $past(chain_q))
    else $error("chain bit lost");

  // Main scenarios
  c_conv: cover property (@(posedge clk) $rose(busy));
  c_pd_conv: cover property (@(posedge clk) busy && s_q.c_sync.power_down);
  c_par: cover property (@(posedge clk) data_oe == '1);
  c_ser: cover property (@(posedge clk) serial_oe);
  c_chain: cover property (@(posedge shift_clk) link_en && !word_new);
endmodule : sarc_top
`default_nettype wire

// [verif/sarc_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module sarc_host_model (
  // Link pins
  output logic      shift_clk,
  output logic      chain_input,
  input  wire logic serial_result_out
);
  // Shift clock stands low between frames
  initial begin
    shift_clk = 1'b0;
    chain_input = 1'b0;
  end
  // Chain bit moves after rise, result taken on fall
  task automatic frame(input int n, input logic [31:0] chn, output logic [47:0] got);
    got = '0;
    for (int i = 0; i < n; i++) begin
      #3 shift_clk = 1'b1;
      chain_input = chn[31-i];
      #3 shift_clk = 1'b0;
      got = {got[46:0], serial_result_out};
    end
    // Released line must not look like held data
    chain_input = ~chain_input;
  endtask : frame
endmodule : sarc_host_model
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sarc_pkg::*;
  localparam int CONV = 10;
  logic             clk, rst_n, clk_en, conversion_start_n, busy;
  logic             shift_clk, chain_input, serial_result_out, serial_oe;
  sarc_ctrl_t       ctrl;
  logic [RES_W-1:0] sample_code, data_out, data_oe;
  logic [47:0]      got;
  logic [31:0]      seed;
  int               num_errors, checked, n;

  sarc_top #(.CONV_CYCLES(CONV)) u_sarc_top (.clk, .rst_n, .clk_en, .conversion_start_n,
    .ctrl, .sample_code, .data_out, .data_oe, .busy, .shift_clk, .chain_input,
    .serial_result_out, .serial_oe);
  sarc_host_model u_sarc_host_model (.shift_clk, .chain_input, .serial_result_out);

  // System clock, 20 ns
  always #10 clk = ~clk;

  // Compare and tally
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Expected bus word: top bit flips for two's complement
  function automatic logic [15:0] fmt(input logic [15:0] c, input logic ob, input logic sw);
    logic [15:0] v;
    v = {c[15] ^ ~ob, c[14:0]};
    return sw ? {v[7:0], v[15:8]} : v;
  endfunction : fmt
  // Start strobe, early return high, extra fall mid-conversion; n counts busy cycles
  task automatic conv(input int mode);
    seed = lfsr(seed);
    sample_code = seed[15:0];
    conversion_start_n = 1'b1;
    repeat (NAP_HIGH_CYC) @(negedge clk);
    n = 0;
    for (int i = 0; i < 40; i++) begin
      conversion_start_n = (i >= 1 && i <= 5);
      if (i == 8 && mode == 1) ctrl.power_down = 1'b1;
      if (i == 8 && mode == 2) ctrl.reset = 1'b1;
      @(negedge clk);
      n += int'(busy === 1'b1);
    end
  endtask : conv
  task automatic complete_run();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Watchdog against a hung handshake
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    conversion_start_n = 1'b1;
    ctrl = '0;
    sample_code = '0;
    seed = 32'h887e;
    u_sarc_host_model.frame(2, '0, got);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      ctrl.code_format_select = k[0];
      ctrl.byte_order_select = k[1];
      conv(0);
      check(n, CONV);
      check(data_out, fmt(sample_code, k[0], k[1]));
      check(data_oe, 16'hffff);
    end
    $display("parallel formats done");
    for (int j = 0; j < 2; j++) begin
      ctrl.cs_n = (j == 0);
      ctrl.rd_n = (j == 1);
      repeat (4) @(negedge clk);
      check(data_oe, 16'h0000);
    end
    ctrl.rd_n = 1'b0;
    ctrl.power_down = 1'b1;
    conv(0);
    check(n, 0);
    ctrl.power_down = 1'b0; // Internal reference modelled, so no long recovery
    conv(1);
    check(n, CONV);
    ctrl.power_down = 1'b0;
    repeat (4) @(negedge clk);
    check(data_out, fmt(sample_code, 1'b1, 1'b1));
    $display("power down done");
    conv(2);
    check(n < CONV, 1'b1);
    check(busy, 1'b0);
    check(data_oe, 16'h0000);
    ctrl.reset = 1'b0;
    repeat (175) @(negedge clk);
    $display("reset abort done");
    ctrl.interface_kind_select = 1'b1;
    for (int k = 0; k < 2; k++) begin
      ctrl.code_format_select = k[0];
      conv(0);
      check(data_oe, 16'h0000);
      check(serial_oe, 1'b1);
      seed = lfsr(seed);
      u_sarc_host_model.frame(32, seed, got);
      check(got[31:0], {fmt(sample_code, k[0], 1'b0), seed[31:16]});
    end
    $display("serial chain done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
